//--- src/bru_unit.sv
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Plain left rotate 90/91: shift left, old bit 7 to bit 0 and carry.
// - Left through carry 10/11: shift left, carry to bit 0, bit 7 to carry.
// - Plain right rotate E0/E1: shift right, old bit 0 to bit 7 and carry.
// - Right through carry C0/C1: shift right, carry to bit 7, bit 0 to carry.
// - Left rotates: carry equals the bit leaving bit 7.
// - Right rotates: carry equals the bit leaving bit 0.
// - Zero flag set exactly when the result byte is zero.
// - Sign flag equals bit 7 of the result.
// - Overflow set when result bit 7 differs from operand bit 7.
// - Indirect mode rotates the pointed-to byte, pointer left unchanged.
module bru_unit
    import bru_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr
);

    // ========================================
    // Helpers
    function automatic bru_decode_t decode_opc(input logic [7:0] opc);
        bru_decode_t d;
        d.legal    = 1'b1;
        d.indirect = opc[0];
        d.kind     = BRU_ROT_L;
        unique case (opc)
            OPC_ROT_L_DIR,  OPC_ROT_L_IND:  d.kind = BRU_ROT_L;
            OPC_ROT_LC_DIR, OPC_ROT_LC_IND: d.kind = BRU_ROT_LC;
            OPC_ROT_R_DIR,  OPC_ROT_R_IND:  d.kind = BRU_ROT_R;
            OPC_ROT_RC_DIR, OPC_ROT_RC_IND: d.kind = BRU_ROT_RC;
            default:                        d.legal = 1'b0;
        endcase
        return d;
    endfunction : decode_opc

    // Only the low index bits select a byte of the small file
    function automatic logic [RF_IDX_W-1:0] rf_index(input logic [7:0] a);
        return a[RF_IDX_W-1:0];
    endfunction : rf_index

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_RESOLVE,
        ST_LOAD,
        ST_WRITE
    } bru_state_t;

    // ========================================
    // Declarations
    bru_state_t          state_r;
    logic [7:0]          opc_r;
    logic [7:0]          dst_r;
    logic [7:0]          ptr_r;
    logic [7:0]          opnd_r;
    logic [RF_IDX_W-1:0] addr_r;
    bru_flags_t          flags_r;
    bru_flags_t          flags_nxt;
    logic                done_r;
    logic                ill_r;
    bru_decode_t         dec_run;
    bru_decode_t         dec_new;
    logic                busy;
    logic                acc;
    logic                wr_acc;
    logic                sel_ctrl;
    logic                sel_stat;
    logic                sel_flags;
    logic                sel_rf;
    logic                mapped;
    logic                wr_blocked;
    logic                go_req;
    logic                launch;
    logic                rf_we;
    logic [RF_IDX_W-1:0] rf_widx;
    logic [7:0]          rf_wdata;
    logic [7:0]          rot_result;
    logic [RF_IDX_W-1:0] rd_idx_a;
    logic [7:0]          rd_data_a;
    logic [7:0]          rd_data_b;

    // ========================================
    // APB decode
    assign busy      = (state_r != ST_IDLE);
    assign acc       = psel && penable;
    assign wr_acc    = acc && pwrite && !pslverr;
    assign sel_ctrl  = (paddr == OFS_CTRL);
    assign sel_stat  = (paddr == OFS_STATUS);
    assign sel_flags = (paddr == OFS_FLAGS);
    assign sel_rf    = (paddr >= OFS_RF_BASE) && (paddr <= OFS_RF_LAST)
                       && (paddr[1:0] == 2'b00);
    assign mapped    = sel_ctrl || sel_stat || sel_flags || sel_rf;
    // Writes that would disturb a running rotate are refused
    assign wr_blocked = pwrite && busy && !sel_stat;
    assign pready    = 1'b1;
    assign pslverr   = acc && (!mapped || wr_blocked);

    assign dec_new = decode_opc(pwdata[CTRL_OPC_LSB +: 8]);
    assign dec_run = decode_opc(opc_r);
    assign go_req  = wr_acc && sel_ctrl && pwdata[CTRL_GO_BIT];
    assign launch  = go_req && dec_new.legal;

    always_comb begin
        prdata = RST_WORD;
        if (sel_ctrl) begin
            prdata[CTRL_OPC_LSB +: 8] = opc_r;
            prdata[CTRL_DST_LSB +: 8] = dst_r;
        end else if (sel_stat) begin
            prdata[STAT_BUSY_BIT] = busy;
            prdata[STAT_DONE_BIT] = done_r;
            prdata[STAT_ILL_BIT]  = ill_r;
        end else if (sel_flags) begin
            prdata[FLAGS_W-1:0] = flags_r;
        end else if (sel_rf) begin
            prdata[7:0] = rd_data_a;
        end
    end

    // ========================================
    // Instruction latch: opcode byte then operand register byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opc_r <= RST_BYTE;
            dst_r <= RST_BYTE;
        end else if (wr_acc && sel_ctrl) begin
            opc_r <= pwdata[CTRL_OPC_LSB +: 8];
            dst_r <= pwdata[CTRL_DST_LSB +: 8];
        end
    end

    // ========================================
    // Sequencer: four states per rotate in either mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE:    if (launch) state_r <= ST_FETCH;
                ST_FETCH:   state_r <= ST_RESOLVE;
                ST_RESOLVE: state_r <= ST_LOAD;
                ST_LOAD:    state_r <= ST_WRITE;
                ST_WRITE:   state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_r <= RST_BYTE;
        end else if (state_r == ST_FETCH) begin
            ptr_r <= rd_data_b;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_r <= '0;
        end else if (state_r == ST_RESOLVE) begin
            // Indirect: the fetched byte names the operand
            addr_r <= dec_run.indirect ? rf_index(ptr_r)
                                       : rf_index(dst_r);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opnd_r <= RST_BYTE;
        end else if (state_r == ST_LOAD) begin
            opnd_r <= rd_data_b;
        end
    end

    // ========================================
    // Flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= RST_FLAGS;
        end else if (state_r == ST_WRITE) begin
            flags_r <= flags_nxt;
        end else if (wr_acc && sel_flags) begin
            flags_r <= bru_flags_t'(pwdata[FLAGS_W-1:0]);
        end
    end

    // Launch and completion never meet: launch needs the idle state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else if (state_r == ST_WRITE) begin
            done_r <= 1'b1;
        end else if (launch) begin
            done_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ill_r <= 1'b0;
        end else if (go_req) begin
            ill_r <= !dec_new.legal;
        end
    end

    // ========================================
    // Register file access
    assign rd_idx_a = paddr[RF_IDX_W+1:2];
    assign rf_we    = (state_r == ST_WRITE) || (wr_acc && sel_rf);
    // Only the operand byte is written back, never the pointer
    assign rf_widx  = (state_r == ST_WRITE) ? addr_r
                                            : rd_idx_a;
    assign rf_wdata = (state_r == ST_WRITE) ? rot_result
                                            : pwdata[7:0];

    bru_regfile u_regfile (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (rf_we),
        .widx    (rf_widx),
        .wdata   (rf_wdata),
        .ridx_a  (rd_idx_a),
        .rdata_a (rd_data_a),
        .ridx_b  ((state_r == ST_FETCH) ? rf_index(dst_r) : addr_r),
        .rdata_b (rd_data_b)
    );

    bru_rotator u_rotator (
        .kind      (dec_run.kind),
        .operand   (opnd_r),
        .flags_in  (flags_r),
        .result    (rot_result),
        .flags_out (flags_nxt)
    );

    // ========================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic wb;
    assign wb = (state_r == ST_WRITE);

    sequence s_launch;
        launch;
    endsequence

    sequence s_walk;
        state_r == ST_FETCH ##1 state_r == ST_RESOLVE
        ##1 state_r == ST_LOAD ##1 state_r == ST_WRITE;
    endsequence

    sequence s_finish;
        ##1 (state_r == ST_IDLE && done_r);
    endsequence

    rot_left_a: assert property (
        wb && dec_run.kind == BRU_ROT_L
        |-> rf_wdata == {opnd_r[6:0], opnd_r[7]} && rf_widx == addr_r)
        else $error("Left rotate result wrong");

    rot_leftc_a: assert property (
        wb && dec_run.kind == BRU_ROT_LC
        |-> rf_wdata == {opnd_r[6:0], flags_r.c})
        else $error("Left rotate through carry result wrong");

    rot_right_a: assert property (
        wb && dec_run.kind == BRU_ROT_R
        |-> rf_wdata == {opnd_r[0], opnd_r[7:1]})
        else $error("Right rotate result wrong");

    rot_rightc_a: assert property (
        wb && dec_run.kind == BRU_ROT_RC
        |-> rf_wdata == {flags_r.c, opnd_r[7:1]})
        else $error("Right rotate through carry result wrong");

    left_carry_a: assert property (
        wb && (dec_run.kind == BRU_ROT_L || dec_run.kind == BRU_ROT_LC)
        |=> flags_r.c == $past(opnd_r[7]))
        else $error("Carry after left rotate wrong");

    right_carry_a: assert property (
        wb && (dec_run.kind == BRU_ROT_R || dec_run.kind == BRU_ROT_RC)
        |=> flags_r.c == $past(opnd_r[0]))
        else $error("Carry after right rotate wrong");

    zero_flag_a: assert property (
        wb |=> flags_r.z == ($past(rf_wdata) == RST_BYTE))
        else $error("Zero flag wrong");

    sign_flag_a: assert property (
        wb |=> flags_r.s == $past(rf_wdata[7]))
        else $error("Sign flag wrong");

    ovf_flag_a: assert property (
        wb |=> flags_r.v == ($past(rf_wdata[7]) ^ $past(opnd_r[7])))
        else $error("Overflow flag wrong");

    ptr_kept_a: assert property (
        wb && dec_run.indirect |-> rf_widx == rf_index(ptr_r))
        else $error("Indirect write went to wrong byte");

    dh_kept_a: assert property (
        wb |=> flags_r.d == $past(flags_r.d)
               && flags_r.h == $past(flags_r.h))
        else $error("Decimal or half-carry flag changed");

    four_cycle_a: assert property (
        s_launch |=> s_walk ##0 s_finish)
        else $error("Rotate did not take four cycles");

    // One write-back per instruction, on the fourth cycle only
    one_write_a: assert property (
        s_launch |=> (!wb) [*3] ##1 wb ##1 !wb)
        else $error("Write-back not on the fourth cycle");

    // A running rotate owns the flags and the file until write-back
    busy_refuse_a: assert property (
        acc && pwrite && busy && !sel_stat |-> pslverr)
        else $error("Write accepted during a rotate");

    flags_hold_a: assert property (
        !wb && !(wr_acc && sel_flags) |=> $stable(flags_r))
        else $error("Flags changed without a rotate or a write");

    direct_dst_a: assert property (
        wb && !dec_run.indirect |-> rf_widx == rf_index(dst_r))
        else $error("Direct write went to wrong byte");

    ovf_sign_a: assert property (
        wb |=> flags_r.v == (flags_r.s ^ $past(opnd_r[7])))
        else $error("Overflow does not match the sign change");

    right_sign_a: assert property (
        wb && dec_run.kind == BRU_ROT_RC
        |=> flags_r.s == $past(flags_r.c))
        else $error("Sign after right rotate through carry wrong");

endmodule : bru_unit

`default_nettype wire

//--- src/bru_pkg.sv
package bru_pkg;

    // ========================================
    // Opcodes
    localparam logic [7:0] OPC_ROT_L_DIR   = 8'h90;
    localparam logic [7:0] OPC_ROT_L_IND   = 8'h91;
    localparam logic [7:0] OPC_ROT_LC_DIR  = 8'h10;
    localparam logic [7:0] OPC_ROT_LC_IND  = 8'h11;
    localparam logic [7:0] OPC_ROT_R_DIR   = 8'hE0;
    localparam logic [7:0] OPC_ROT_R_IND   = 8'hE1;
    localparam logic [7:0] OPC_ROT_RC_DIR  = 8'hC0;
    localparam logic [7:0] OPC_ROT_RC_IND  = 8'hC1;

    // ========================================
    // Register map (byte addresses)
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_STATUS     = 8'h04;
    localparam logic [7:0]  OFS_FLAGS      = 8'h08;
    localparam logic [7:0]  OFS_RF_BASE    = 8'h40;
    localparam logic [7:0]  OFS_RF_LAST    = 8'h7C;

    // CTRL fields
    localparam int          CTRL_OPC_LSB   = 0;
    localparam int          CTRL_DST_LSB   = 8;
    localparam int          CTRL_GO_BIT    = 16;
    // STATUS fields
    localparam int          STAT_BUSY_BIT  = 0;
    localparam int          STAT_DONE_BIT  = 1;
    localparam int          STAT_ILL_BIT   = 2;
    // FLAGS fields: bit0 C, 1 Z, 2 S, 3 V, 4 D, 5 H
    localparam int          FLAGS_W        = 6;

    // ========================================
    // Register file and timing
    localparam int          RF_DEPTH       = 16;
    localparam int          RF_IDX_W       = 4;
    localparam int          ROT_CYCLES     = 4;

    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [31:0] RST_WORD       = 32'h0000_0000;

    // ========================================
    // Types
    typedef enum logic [1:0] {
        BRU_ROT_L,
        BRU_ROT_LC,
        BRU_ROT_R,
        BRU_ROT_RC
    } bru_kind_t;

    typedef struct packed {
        logic h;
        logic d;
        logic v;
        logic s;
        logic z;
        logic c;
    } bru_flags_t;

    typedef struct packed {
        logic       legal;
        logic       indirect;
        bru_kind_t  kind;
    } bru_decode_t;

    localparam bru_flags_t RST_FLAGS = '0;

endpackage : bru_pkg

//--- src/bru_rotator.sv
`timescale 1ns/100ps
`default_nettype none

module bru_rotator
    import bru_pkg::*;
(
    input  wire bru_kind_t  kind,
    input  wire logic [7:0] operand,
    input  wire bru_flags_t flags_in,
    output logic [7:0]      result,
    output bru_flags_t      flags_out
);

    // ========================================
    // Rotate datapath
    always_comb begin
        flags_out = flags_in;
        result    = operand;
        unique case (kind)
            BRU_ROT_L: begin
                result = {operand[6:0], operand[7]};
                flags_out.c = operand[7];
            end
            BRU_ROT_LC: begin
                result = {operand[6:0], flags_in.c};
                flags_out.c = operand[7];
            end
            BRU_ROT_R: begin
                result = {operand[0], operand[7:1]};
                flags_out.c = operand[0];
            end
            BRU_ROT_RC: begin
                result = {flags_in.c, operand[7:1]};
                flags_out.c = operand[0];
            end
        endcase
        flags_out.z = (result == RST_BYTE);
        flags_out.s = result[7];
        // Sign change across the rotate is the overflow
        flags_out.v = result[7] ^ operand[7];
    end

endmodule : bru_rotator

`default_nettype wire

//--- src/bru_regfile.sv
`timescale 1ns/100ps
`default_nettype none

module bru_regfile
    import bru_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                we,
    input  wire logic [RF_IDX_W-1:0] widx,
    input  wire logic [7:0]          wdata,
    input  wire logic [RF_IDX_W-1:0] ridx_a,
    output logic [7:0]               rdata_a,
    input  wire logic [RF_IDX_W-1:0] ridx_b,
    output logic [7:0]               rdata_b
);

    logic [7:0] mem_r [RF_DEPTH];

    // ========================================
    // Storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < RF_DEPTH; i++) begin
                mem_r[i] <= RST_BYTE;
            end
        end else if (we) begin
            mem_r[widx] <= wdata;
        end
    end

    assign rdata_a = mem_r[ridx_a];
    assign rdata_b = mem_r[ridx_b];

endmodule : bru_regfile

`default_nettype wire

//--- tb/bru_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ========================================
// Core side: issues register accesses over APB
module bru_host_model
    import bru_pkg::*;
(
    input  wire logic         pclk,
    output logic              psel,
    output logic              penable,
    output logic              pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [31:0]       pwdata,
    input  wire logic [31:0]  prdata,
    input  wire logic         pready,
    input  wire logic         pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end

    // Request held until pready seen high, for at most 16 cycles; idle gives a slow caller
    task automatic xfer(input int idle, input logic w,
                        input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e,
                        output logic ok);
        int n;
        ok = 1'b0;
        r  = '0;
        e  = 1'b0;
        repeat (idle) @(posedge pclk);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                ok = 1'b1;
                r  = prdata;
                e  = pslverr;
            end
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : bru_host_model

`default_nettype wire

//--- tb/bru_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none

// ========================================
// Bench: rotates driven through the register bus
module bru_unit_tb
    import bru_pkg::*;
();
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [31:0]       r;
    int                num_errors;
    int                n_tests;
    int                gap;
    int                i;
    int                j;
    int                k;
    logic [7:0]        ops  [8];
    logic [7:0]        vals [6];
    logic [7:0]        ra   [4];

    bru_unit bru_unit_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    bru_host_model bru_host_model_inst (
        .pclk    (pclk),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    always #25 pclk = ~pclk;

    // ========================================
    // Checks and bus access
    task automatic final_report();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic chk_bit(input string nm, input logic ex, input logic got);
        n_tests++;
        if (got !== ex) begin
            num_errors++;
            $display("FAIL %s expected %b seen %b", nm, ex, got);
        end
    endtask : chk_bit

    task automatic xf(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic ee);
        logic e;
        logic ok;
        bru_host_model_inst.xfer(gap, w, a, d, r, e, ok);
        if (ok !== 1'b1) begin
            num_errors++;
            final_report();
        end else begin
            chk_bit("slverr", ee, e);
        end
    endtask : xf

    function automatic logic [7:0] rfa(input logic [3:0] x);
        return OFS_RF_BASE + {2'b00, x, 2'b00};
    endfunction : rfa

    // Returns carry out above the result byte
    function automatic logic [8:0] ref_rot(input logic [7:0] op,
                                          input logic [7:0] v,
                                          input logic c);
        case ({op[7:1], 1'b0})
            OPC_ROT_L_DIR:  return {v[7], v[6:0], v[7]};
            OPC_ROT_LC_DIR: return {v[7], v[6:0], c};
            OPC_ROT_R_DIR:  return {v[0], v[0], v[7:1]};
            default:        return {v[0], c, v[7:1]};
        endcase
    endfunction : ref_rot

    // Bounded poll; a hang ends the run
    task automatic wait_done();
        int n;
        for (n = 0; n < 20; n++) begin
            xf(1'b0, OFS_STATUS, 32'h0, 1'b0);
            if (r[STAT_DONE_BIT] === 1'b1) begin
                return;
            end
        end
        num_errors++;
        final_report();
    endtask : wait_done

    // Pointer in entry 5 names entry 9; direct operand sits in entry 3
    task automatic run(input logic [7:0] op, input logic [7:0] v,
                       input logic c);
        logic [8:0] x;
        logic [3:0] t;
        t = op[0] ? 4'h9 : 4'h3;
        xf(1'b1, OFS_FLAGS, {26'h0, ~c, c, c, c, c, c}, 1'b0);
        xf(1'b1, rfa(4'h5), 32'h0000_0009, 1'b0);
        xf(1'b1, rfa(t), {24'h0, v}, 1'b0);
        xf(1'b1, OFS_CTRL, {15'h0, 1'b1, 4'h0, 1'b0, op[0], ~op[0], 1'b1, op},
           1'b0);
        wait_done();
        x = ref_rot(op, v, c);
        xf(1'b0, rfa(t), 32'h0, 1'b0);
        chk("result", {24'h0, x[7:0]}, r);
        xf(1'b0, OFS_FLAGS, 32'h0, 1'b0);
        chk_bit("carry", x[8], r[0]);
        chk_bit("zero", x[7:0] == 8'h00, r[1]);
        chk_bit("sign", x[7], r[2]);
        chk_bit("overflow", x[7] ^ v[7], r[3]);
        chk("dh", {30'h0, ~c, c}, {30'h0, r[5:4]});
        if (op[0]) begin
            xf(1'b0, rfa(4'h5), 32'h0, 1'b0);
            chk("pointer", 32'h0000_0009, r);
        end
    endtask : run

    // ========================================
    // Main sequence
    initial begin
        pclk       = 1'b0;
        presetn    = 1'b0;
        num_errors = 0;
        n_tests    = 0;
        gap        = 0;
        ops  = '{OPC_ROT_L_DIR, OPC_ROT_L_IND, OPC_ROT_LC_DIR,
                 OPC_ROT_LC_IND, OPC_ROT_R_DIR, OPC_ROT_R_IND,
                 OPC_ROT_RC_DIR, OPC_ROT_RC_IND};
        vals = '{8'hAA, 8'h31, 8'h00, 8'h80, 8'h01, 8'h17};
        ra   = '{OFS_CTRL, OFS_STATUS, OFS_FLAGS, OFS_RF_BASE};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 4; i++) begin
            xf(1'b0, ra[i], 32'h0, 1'b0);
            chk("reset", RST_WORD, r);
        end
        xf(1'b0, 8'h20, 32'h0, 1'b1);
        xf(1'b1, 8'h41, 32'h0000_0055, 1'b1);
        xf(1'b1, OFS_CTRL, 32'h0001_0312, 1'b0);
        xf(1'b0, OFS_STATUS, 32'h0, 1'b0);
        chk("illegal", 32'h0000_0004, r);
        for (i = 0; i < 8; i++) begin
            for (j = 0; j < 6; j++) begin
                for (k = 0; k < 2; k++) begin
                    gap = j % 3;
                    run(ops[i], vals[j], k[0]);
                end
            end
        end
        // Back-to-back access while the rotate is in flight
        gap = 0;
        xf(1'b1, OFS_FLAGS, 32'h0, 1'b0);
        xf(1'b1, OFS_CTRL, 32'h0001_0390, 1'b0);
        xf(1'b1, OFS_FLAGS, 32'h0000_0030, 1'b1);
        xf(1'b0, OFS_STATUS, 32'h0, 1'b0);
        chk_bit("done", 1'b1, r[STAT_DONE_BIT]);
        xf(1'b0, OFS_FLAGS, 32'h0, 1'b0);
        chk("dh kept", 32'h0, {26'h0, r[5:4], 4'h0});
        xf(1'b1, OFS_CTRL, 32'h0001_03E1, 1'b0);
        xf(1'b0, OFS_STATUS, 32'h0, 1'b0);
        chk_bit("busy", 1'b1, r[STAT_BUSY_BIT]);
        xf(1'b0, OFS_STATUS, 32'h0, 1'b0);
        chk("finish", 32'h0000_0002, r);
        final_report();
    end

    initial begin
        repeat (100000) @(posedge pclk);
        num_errors++;
        final_report();
    end
endmodule : bru_unit_tb

`default_nettype wire
